// >>> design/bcbd_break_unit.sv
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module bcbd_break_unit #(
  parameter int AW = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic busValid,
  input wire logic [AW-1:0] busAddr,
  input wire logic busIsDma,
  input wire logic busIsFetch,
  input wire logic busIsWrite,
  input wire logic [1:0] busSize,
  input wire logic fetchPair,
  input wire logic [3:0] intMaskLevel,
  input wire logic cpuInhibit,
  input wire logic [AW-1:0] cpuNextPc,
  input wire logic intAck,
  output logic brkReq,
  output logic [3:0] brkLevel,
  output logic [AW-1:0] savedPc
);
  // ==========================================
  // bus slave state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ANSWER = 2'b01
  } bcbd_state_t;
  bcbd_state_t state_reg;
  bcbd_state_t state_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wait_reg;
  logic doWrite;
  // ==========================================
  // break condition registers
  logic [15:0] addrHi_reg;
  logic [15:0] addrLo_reg;
  logic [15:0] maskHi_reg;
  logic [15:0] maskLo_reg;
  logic [15:0] cycSel_reg;
  // ==========================================
  // break tracking
  logic pend_reg;
  logic pend_next;
  logic req_reg;
  logic [3:0] lvl_reg;
  logic second_reg;
  logic dataBrk_reg;
  logic [AW-1:0] cand_reg;
  logic [AW-1:0] pc_reg;
  logic [AW-1:0] brkAddr;
  logic [AW-1:0] brkMask;
  logic [AW-1:0] addr2;
  logic hitFirst;
  logic hitSecond;
  logic attrHit;
  logic matchFirst;
  logic matchSecond;
  logic anyMatch;
  logic accept;

  // ==========================================
  // byte lane merge
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // ==========================================
  // write strobe decode per register index
  function automatic logic regWr(
    input logic [4:0] idx
  );
    return doWrite && (address == idx);
  endfunction

  // ==========================================
  // avalon handshake
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (read || write) begin
          state_next = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign doWrite = write && (state_reg == ST_ANSWER);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b1;
    end else if (ce) begin
      wait_reg <= !(state_reg == ST_IDLE && (read || write));
    end
  end

  // ==========================================
  // read mux, unmapped reads as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (address)
      bcbd_pkg::IDX_ADDR_HI: rdata_next[15:0] = addrHi_reg;
      bcbd_pkg::IDX_ADDR_LO: rdata_next[15:0] = addrLo_reg;
      bcbd_pkg::IDX_MASK_HI: rdata_next[15:0] = maskHi_reg;
      bcbd_pkg::IDX_MASK_LO: rdata_next[15:0] = maskLo_reg;
      bcbd_pkg::IDX_CYC_SEL: rdata_next[15:0] = cycSel_reg;
      bcbd_pkg::IDX_STATUS: begin
        rdata_next[bcbd_pkg::ST_PEND_BIT] = pend_reg;
        rdata_next[bcbd_pkg::ST_SECOND_BIT] = second_reg;
        rdata_next[bcbd_pkg::ST_DATA_BIT] = dataBrk_reg;
      end
      bcbd_pkg::IDX_PC_HI: rdata_next[15:0] = pc_reg[31:16];
      bcbd_pkg::IDX_PC_LO: rdata_next[15:0] = pc_reg[15:0];
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= bcbd_pkg::RDATA_RST;
    end else if (ce) begin
      if (read && state_reg == ST_IDLE) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ==========================================
  // address and mask halves
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addrHi_reg <= bcbd_pkg::HALF_RST;
      addrLo_reg <= bcbd_pkg::HALF_RST;
    end else if (ce) begin
      if (regWr(bcbd_pkg::IDX_ADDR_HI)) begin
        addrHi_reg <= merge16(addrHi_reg, writedata, byteenable);
      end
      if (regWr(bcbd_pkg::IDX_ADDR_LO)) begin
        addrLo_reg <= merge16(addrLo_reg, writedata, byteenable);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      maskHi_reg <= bcbd_pkg::HALF_RST;
      maskLo_reg <= bcbd_pkg::HALF_RST;
    end else if (ce) begin
      if (regWr(bcbd_pkg::IDX_MASK_HI)) begin
        maskHi_reg <= merge16(maskHi_reg, writedata, byteenable);
      end
      if (regWr(bcbd_pkg::IDX_MASK_LO)) begin
        maskLo_reg <= merge16(maskLo_reg, writedata, byteenable);
      end
    end
  end

  // ==========================================
  // cycle select, only resetn clears it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cycSel_reg <= bcbd_pkg::CYC_SEL_RST;
    end else if (ce && regWr(bcbd_pkg::IDX_CYC_SEL)) begin
      cycSel_reg <= merge16(cycSel_reg, writedata, byteenable)
        & bcbd_pkg::CYC_SEL_WMASK;
    end
  end

  // ==========================================
  // match logic
  assign brkAddr = {addrHi_reg, addrLo_reg};
  assign brkMask = {maskHi_reg, maskLo_reg};
  assign addr2 = busAddr + AW'(bcbd_pkg::INSTR_STEP);

  bcbd_cyc_if cycBus ();
  assign cycBus.isDma = busIsDma;
  assign cycBus.isFetch = busIsFetch;
  assign cycBus.isWrite = busIsWrite;
  assign cycBus.size = busSize;
  assign cycBus.cycSel = cycSel_reg[7:0];
  assign attrHit = cycBus.hit;

  bcbd_attr_match uAttr (
    .cyc(cycBus.chk)
  );

  bcbd_addr_match #(.AW(AW)) uAddrFirst (
    .addr(busAddr),
    .brkAddr(brkAddr),
    .brkMask(brkMask),
    .hit(hitFirst)
  );

  bcbd_addr_match #(.AW(AW)) uAddrSecond (
    .addr(addr2),
    .brkAddr(brkAddr),
    .brkMask(brkMask),
    .hit(hitSecond)
  );

  assign matchFirst = busValid && attrHit && hitFirst;
  assign matchSecond = busValid && attrHit && busIsFetch && fetchPair
    && hitSecond && !hitFirst;
  assign anyMatch = matchFirst || matchSecond;
  assign accept = req_reg && intAck;

  // ==========================================
  // pending flag, a new match beats the ack
  always_comb begin
    pend_next = pend_reg;
    if (accept) begin
      pend_next = 1'b0;
    end
    if (anyMatch) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
    end else if (ce) begin
      pend_reg <= pend_next;
    end
  end

  // ==========================================
  // request offered only below level 15
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_reg <= 1'b0;
    end else if (ce) begin
      req_reg <= pend_next && (intMaskLevel <= bcbd_pkg::ACCEPT_MAX);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lvl_reg <= bcbd_pkg::LVL_RST;
    end else if (ce) begin
      lvl_reg <= bcbd_pkg::BRK_PRIO;
    end
  end

  // ==========================================
  // candidate pc of the held break
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cand_reg <= AW'(bcbd_pkg::PC_RST);
    end else if (ce && anyMatch && (!pend_reg || accept)) begin
      cand_reg <= matchFirst ? busAddr : addr2;
    end
  end

  // ==========================================
  // status bits of the held break
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      second_reg <= 1'b0;
      dataBrk_reg <= 1'b0;
    end else if (ce && anyMatch && (!pend_reg || accept)) begin
      second_reg <= !matchFirst;
      dataBrk_reg <= !busIsFetch;
    end
  end

  // ==========================================
  // pc saved when the break is accepted
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= AW'(bcbd_pkg::PC_RST);
    end else if (ce && accept) begin
      if (dataBrk_reg) begin
        pc_reg <= cpuNextPc;
      end else if (cpuInhibit) begin
        pc_reg <= cpuNextPc;
      end else begin
        pc_reg <= cand_reg;
      end
    end
  end

  // ==========================================
  // outputs
  assign readdata = rdata_reg;
  assign waitrequest = wait_reg;
  assign brkReq = req_reg;
  assign brkLevel = lvl_reg;
  assign savedPc = pc_reg;
endmodule
`default_nettype wire

// >>> common/bcbd_pkg.sv
package bcbd_pkg;
  // ==========================================
  // register indices (byte address = 4 * index)
  localparam logic [4:0] IDX_ADDR_HI = 5'h00;
  localparam logic [4:0] IDX_ADDR_LO = 5'h02;
  localparam logic [4:0] IDX_MASK_HI = 5'h04;
  localparam logic [4:0] IDX_MASK_LO = 5'h06;
  localparam logic [4:0] IDX_CYC_SEL = 5'h08;
  localparam logic [4:0] IDX_STATUS = 5'h0A;
  localparam logic [4:0] IDX_PC_HI = 5'h0C;
  localparam logic [4:0] IDX_PC_LO = 5'h0E;
  // ==========================================
  // reset values and write masks
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [15:0] CYC_SEL_RST = 16'h0000;
  localparam logic [15:0] CYC_SEL_WMASK = 16'h00FF;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [3:0] LVL_RST = 4'h0;
  // ==========================================
  // field positions of break_cycle_select
  localparam int SRC_LSB = 6;
  localparam int CLS_LSB = 4;
  localparam int DIR_LSB = 2;
  localparam int SIZE_LSB = 0;
  // status bit positions
  localparam int ST_PEND_BIT = 0;
  localparam int ST_SECOND_BIT = 1;
  localparam int ST_DATA_BIT = 2;
  // ==========================================
  // operand size codes
  typedef enum logic [1:0] {
    SZ_ANY = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10,
    SZ_LONG = 2'b11
  } bcbd_size_t;
  // ==========================================
  // priority and address step
  localparam logic [3:0] BRK_PRIO = 4'hF;
  localparam logic [3:0] ACCEPT_MAX = 4'hE;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0002;
endpackage

// >>> common/bcbd_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bcbd_cyc_if;
  logic isDma;
  logic isFetch;
  logic isWrite;
  logic [1:0] size;
  logic [7:0] cycSel;
  logic hit;
  modport mon (output isDma, output isFetch, output isWrite, output size,
    output cycSel, input hit);
  modport chk (input isDma, input isFetch, input isWrite, input size,
    input cycSel, output hit);
endinterface
`default_nettype wire

// >>> design/bcbd_attr_match.sv
`timescale 1ns/1ps
`default_nettype none
module bcbd_attr_match (
  bcbd_cyc_if.chk cyc
);
  // ==========================================
  // attribute decode
  logic [1:0] srcSel;
  logic [1:0] clsSel;
  logic [1:0] dirSel;
  logic [1:0] sizeSel;
  logic [1:0] effSize;
  logic srcOk;
  logic clsOk;
  logic dirOk;
  logic sizeOk;
  assign srcSel = cyc.cycSel[bcbd_pkg::SRC_LSB +: 2];
  assign clsSel = cyc.cycSel[bcbd_pkg::CLS_LSB +: 2];
  assign dirSel = cyc.cycSel[bcbd_pkg::DIR_LSB +: 2];
  assign sizeSel = cyc.cycSel[bcbd_pkg::SIZE_LSB +: 2];
  assign srcOk = cyc.isDma ? srcSel[1] : srcSel[0];
  assign clsOk = cyc.isFetch ? clsSel[0] : clsSel[1];
  assign dirOk = cyc.isWrite ? dirSel[1] : dirSel[0];
  // fetches always count as word size
  assign effSize = cyc.isFetch ? bcbd_pkg::SZ_WORD : cyc.size;
  assign sizeOk = (sizeSel == bcbd_pkg::SZ_ANY) || (sizeSel == effSize);
  assign cyc.hit = srcOk && clsOk && dirOk && sizeOk;
endmodule
`default_nettype wire

// >>> design/bcbd_addr_match.sv
`timescale 1ns/1ps
`default_nettype none
module bcbd_addr_match #(
  parameter int AW = 32
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] brkAddr,
  input wire logic [AW-1:0] brkMask,
  output logic hit
);
  // ==========================================
  // masked compare, mask bit 1 drops the bit
  assign hit = ((addr ^ brkAddr) & ~brkMask) == '0;
endmodule
`default_nettype wire

// >>> bench/bcbd_break_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// port checks of the break unit
module bcbd_break_unit_checker #(
  parameter int AW = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic busValid,
  input wire logic [3:0] intMaskLevel,
  input wire logic intAck,
  input wire logic brkReq,
  input wire logic [3:0] brkLevel,
  input wire logic [AW-1:0] savedPc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn || !ce);
  property p_level;
    brkReq |-> brkLevel == bcbd_pkg::BRK_PRIO;
  endproperty
  a_level: assert property (p_level) else $error("break level wrong");
  property p_accept;
    $rose(brkReq) |-> $past(intMaskLevel) <= bcbd_pkg::ACCEPT_MAX;
  endproperty
  a_accept: assert property (p_accept) else $error("request under mask");
  property p_hold;
    brkReq && !intAck && intMaskLevel <= bcbd_pkg::ACCEPT_MAX |=> brkReq;
  endproperty
  a_hold: assert property (p_hold) else $error("request lost");
  property p_drop;
    brkReq && intAck && !busValid |=> !brkReq;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept");
  property p_cause;
    $rose(brkReq) |-> $past(busValid) || $past(intMaskLevel, 2) > bcbd_pkg::ACCEPT_MAX;
  endproperty
  a_cause: assert property (p_cause) else $error("request without cycle");
  property p_pc;
    $changed(savedPc) |-> $past(intAck) && $past(brkReq);
  endproperty
  a_pc: assert property (p_pc) else $error("pc moved without accept");
  property p_answer;
    $rose(read || write) |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_rsv;
    read && !waitrequest && address == bcbd_pkg::IDX_CYC_SEL |-> readdata[15:8] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("upper byte not zero");
endmodule
bind bcbd_break_unit bcbd_break_unit_checker #(.AW(AW)) u_chk (.clk_sys, .resetn, .address,
  .read, .write, .readdata, .waitrequest, .busValid, .intMaskLevel, .intAck, .brkReq,
  .brkLevel, .savedPc, .ce);
`default_nettype wire

// >>> bench/bcbd_bus_src.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// cpu and dma bus cycle source
module bcbd_bus_src (
  input wire logic clk_sys,
  output logic busValid,
  output logic [31:0] busAddr,
  output logic busIsDma,
  output logic busIsFetch,
  output logic busIsWrite,
  output logic [1:0] busSize,
  output logic fetchPair
);
  initial begin
    {busValid, busAddr, busIsDma, busIsFetch, busIsWrite, busSize, fetchPair} = '0;
  end
  // one cycle; t = dma, fetch, write, size, pair
  task automatic cyc(input logic [31:0] a, input logic [5:0] t);
    @(posedge clk_sys);
    busValid <= 1'b1;
    busAddr <= a;
    {busIsDma, busIsFetch, busIsWrite, busSize, fetchPair} <= t;
    @(posedge clk_sys);
    busValid <= 1'b0;
    busAddr <= ~a;
  endtask
endmodule
`default_nettype wire

// >>> bench/bcbd_break_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bcbd_break_unit_tb;
  localparam logic [4:0] SEL = bcbd_pkg::IDX_CYC_SEL;
  localparam logic [4:0] HI = bcbd_pkg::IDX_ADDR_HI;
  localparam logic [4:0] LO = bcbd_pkg::IDX_ADDR_LO;
  localparam logic [31:0] A = 32'h0000_0404;
  localparam logic [31:0] P = 32'h1234_5678;
  logic clk_sys, resetn, read, write, waitrequest, busValid, busIsDma, busIsFetch;
  logic busIsWrite, fetchPair, cpuInhibit, intAck, brkReq, ce;
  logic [4:0] address;
  logic [3:0] byteenable, intMaskLevel, brkLevel;
  logic [31:0] writedata, readdata, busAddr, cpuNextPc, savedPc;
  logic [1:0] busSize;
  logic [7:0] sel;
  logic [5:0] at;
  int n_fail = 0;
  int check_count = 0;
  bcbd_break_unit uut (.clk_sys, .resetn, .ce, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .busValid, .busAddr, .busIsDma, .busIsFetch,
    .busIsWrite, .busSize, .fetchPair, .intMaskLevel, .cpuInhibit, .cpuNextPc, .intAck,
    .brkReq, .brkLevel, .savedPc);
  bcbd_bus_src src (.clk_sys, .busValid, .busAddr, .busIsDma, .busIsFetch, .busIsWrite,
    .busSize, .fetchPair);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ========================================
  // checks and bus access
  task automatic bad(input string m);
    n_fail++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      bad(m);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    {write, read, address, writedata} <= {w, !w, a, 16'h0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    {write, read} <= 2'b00;
    if (n >= 20) begin
      bad("no bus answer");
      close_out();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [31:0] q;
    acc(1'b0, a, 16'h0000, q);
    chk(q, {16'h0000, e}, "read value");
  endtask
  // ========================================
  // break trials
  task automatic ack(input logic [31:0] p);
    chk(brkLevel, 4'hF, "break level");
    intAck <= 1'b1;
    @(posedge clk_sys);
    intAck <= 1'b0;
    @(posedge clk_sys);
    chk(savedPc, p, "saved pc");
    chk(brkReq, 1'b0, "request after accept");
  endtask
  task automatic trial(input logic [7:0] s, input logic [31:0] a, input logic [5:0] t,
    input logic e, input logic [31:0] p);
    wr(SEL, {8'h00, s});
    src.cyc(a, t);
    @(posedge clk_sys);
    chk(brkReq, e, "break request");
    if (brkReq === 1'b1) begin
      ack(p);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ========================================
  // main sequence
  initial begin
    {resetn, read, write, address, writedata, intAck, cpuInhibit} = '0;
    byteenable = 4'hF;
    ce = 1'b1;
    intMaskLevel = 4'h0;
    cpuNextPc = P;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(SEL, 16'h0000);
    wr(SEL, 16'hFFFF);
    rd(SEL, 16'h00FF);
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    wr(HI, 16'h0012);
    wr(LO, 16'h3456);
    rd(HI, 16'h0012);
    trial(8'hFC, 32'h0012_3456, 6'h04, 1'b1, P);
    trial(8'hFC, 32'h0013_3456, 6'h04, 1'b0, P);
    $display("test registers done");
    wr(HI, 16'h0000);
    wr(LO, 16'h0404);
    for (int k = 0; k < 3; k++) begin
      for (int v = 1; v < 4; v++) begin
        for (int b = 0; b < 2; b++) begin
          sel = 8'hFC;
          sel[7-2*k -: 2] = v[1:0];
          at = 6'h04;
          at[5-k] = (k == 1) ^ b[0];
          trial(sel, A, at, v[b], at[4] ? A : P);
        end
      end
      trial(8'hFC & ~(8'hC0 >> 2*k), A, 6'h04, 1'b0, P);
    end
    for (int s = 1; s < 4; s++) begin
      for (int z = 1; z < 4; z++) begin
        trial({6'h3F, s[1:0]}, A, {3'b000, z[1:0], 1'b0}, s == z, P);
      end
    end
    trial(8'hF6, A, 6'h12, 1'b1, A);
    trial(8'hF6, A, 6'h16, 1'b1, A);
    trial(8'hF6, A, 6'h02, 1'b0, P);
    $display("test fields done");
    wr(bcbd_pkg::IDX_MASK_LO, 16'h000F);
    trial(8'hFC, 32'h0000_040B, 6'h04, 1'b1, P);
    trial(8'hFC, 32'h0000_0414, 6'h04, 1'b0, P);
    wr(bcbd_pkg::IDX_MASK_LO, 16'h0000);
    trial(8'hA7, A, 6'h26, 1'b1, P);
    rd(bcbd_pkg::IDX_STATUS, 16'h0004);
    trial(8'h54, A, 6'h14, 1'b1, A);
    cpuInhibit <= 1'b1;
    trial(8'h54, A, 6'h14, 1'b1, P);
    rd(bcbd_pkg::IDX_PC_HI, 16'h1234);
    cpuInhibit <= 1'b0;
    wr(LO, 16'h0406);
    trial(8'h54, A, 6'h15, 1'b1, 32'h0000_0406);
    rd(bcbd_pkg::IDX_STATUS, 16'h0002);
    rd(bcbd_pkg::IDX_PC_LO, 16'h0406);
    $display("test address and pc done");
    intMaskLevel <= 4'hF;
    src.cyc(32'h0000_0406, 6'h14);
    repeat (4) @(posedge clk_sys);
    chk(brkReq, 1'b0, "request while masked");
    rd(bcbd_pkg::IDX_STATUS, 16'h0001);
    intMaskLevel <= 4'hE;
    repeat (2) @(posedge clk_sys);
    chk(brkReq, 1'b1, "pending request");
    ack(32'h0000_0406);
    $display("test pending done");
    ce <= 1'b0;
    src.cyc(32'h0000_0406, 6'h14);
    ce <= 1'b1;
    @(posedge clk_sys);
    chk(brkReq, 1'b0, "match taken while frozen");
    $display("test enable done");
    resetn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(SEL, 16'h0000);
    rd(LO, 16'h0000);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
